// *** rtl/irq_lp_pkg.sv ***
// package: constants and carriers for the interrupt and power-mode block
package irq_lp_pkg;

  // vector word addresses and priorities
  localparam logic [15:0] VEC_RESET     = 16'hfffe;
  localparam logic [15:0] VEC_NMI       = 16'hfffc;
  localparam logic [15:0] VEC_COMP      = 16'hfff6;
  localparam logic [15:0] VEC_WDT       = 16'hfff4;
  localparam logic [15:0] VEC_TMR0      = 16'hfff2;
  localparam logic [15:0] VEC_TMR1      = 16'hfff0;
  localparam logic [15:0] VEC_PORT2     = 16'hffe6;
  localparam logic [15:0] VEC_PORT1     = 16'hffe4;
  localparam logic [15:0] VEC_TOP       = 16'hffff;
  localparam logic [15:0] VEC_BASE      = 16'hffc0;
  localparam logic [15:0] VEC_FREE_TOP  = 16'hffde;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;
  localparam logic [4:0]  PRI_RESET     = 5'h1f;
  localparam logic [4:0]  PRI_NMI       = 5'h1e;
  localparam logic [4:0]  PRI_COMP      = 5'h1b;
  localparam logic [4:0]  PRI_WDT       = 5'h1a;
  localparam logic [4:0]  PRI_TMR0      = 5'h19;
  localparam logic [4:0]  PRI_TMR1      = 5'h18;
  localparam logic [4:0]  PRI_PORT2     = 5'h13;
  localparam logic [4:0]  PRI_PORT1     = 5'h12;

  // fetch range limits: register space top, then ranges allowed for fetch
  localparam logic [15:0] PERIPH_TOP    = 16'h01ff;
  localparam logic [15:0] RAM_BASE      = 16'h0200;
  localparam logic [15:0] RAM_TOP       = 16'h027f;
  localparam logic [15:0] INFO_BASE     = 16'h1000;
  localparam logic [15:0] INFO_TOP      = 16'h10ff;
  localparam logic [15:0] CODE_BASE_DEF = 16'hf800;

  // register map over the bus
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CFG    = 8'h10;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // reset values
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [4:0] FLAGS_RST  = 5'h00;

  typedef enum logic [5:0] {
    active_run_state  = 6'b000001,
    sleep_level_zero  = 6'b000010,
    sleep_level_one   = 6'b000100,
    sleep_level_two   = 6'b001000,
    sleep_level_three = 6'b010000,
    sleep_level_four  = 6'b100000
  } power_mode_t;

  // reset causes from other logic
  typedef struct packed {
    logic power_up;
    logic ext_reset;
    logic watchdog;
    logic key_violation;
  } reset_src_t;

  // maskable peripheral requests
  typedef struct packed {
    logic       comparator_flag;
    logic       watchdog_flag;
    logic       timer_ch0_flag;
    logic       timer_ch1_flag;
    logic       timer_overflow_flag;
    logic [1:0] port2_change_flags;
    logic [7:0] port1_change_flags;
  } mask_req_t;

  // clock and oscillator gates
  typedef struct packed {
    logic cpu_run;
    logic main_clk_en;
    logic peripheral_submain_clock_en;
    logic aux_clk_en;
    logic dc_bias_en;
    logic crystal_en;
  } clk_gate_t;

endpackage

// *** rtl/vectored_interrupt_lowpower_ctl.sv ***
// interrupt vectoring, fetch guard and power-mode clock gating
// Behaviour
// - vector table spans ffff down to ffc0, each entry a 16-bit handler
// - erased reset vector after power-up sends device to deepest sleep
// - power-up, reset pin, watchdog, key and fetch faults reset, priority 31
// - pin nmi, oscillator fault, flash access share fffc at priority 30
// - non-maskable sources gated by own enable, never by global enable
// - comparator interrupt maskable, slot fff6 priority 27, optional
// - watchdog interval fff4 priority 26; timer channel zero fff2 priority 25
// - timer channel one and overflow share fff0 at priority 24
// - port 2 bits 6 and 7 share ffe6 at priority 19
// - port 1 eight flags share ffe4 at priority 18
// - slots ffde down to ffc0 carry no source, act as memory
// - fetch from 0 to 1ff or unused range forces system reset
// - enabled interrupt wakes any sleep; return restores prior sleep mode
// - active mode runs all three clocks
// - sleep zero and one stop cpu and main clock, others run
// - sleep one drops dc bias unless tuned oscillator drives active mode
// - sleep two stops main and peripheral clocks, keeps bias and aux
// - sleep three keeps only the auxiliary clock running
// - sleep four stops all clocks, bias and crystal
// - pin nmi flag set by reset pin in nmi use; power-on flag on power-up
`timescale 1ns/1ps
module vectored_interrupt_lowpower_ctl
  import irq_lp_pkg::*;
#(
  parameter bit          HAS_COMPARATOR = 1'b1,
  parameter logic [15:0] CODE_BASE      = CODE_BASE_DEF
)(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // processor core side
  input  wire logic                 fetch_valid,
  input  wire logic [15:0]          fetch_addr,
  input  wire logic                 reset_vec_valid,
  input  wire logic [15:0]          reset_vec_word,
  input  wire logic                 gie,
  input  wire logic                 mode_req_valid,
  input  wire logic [2:0]           mode_req,
  input  wire logic                 irq_ack,
  input  wire logic                 irq_return,
  output logic                      irq_req,
  output logic [15:0]               irq_vector_addr,
  output logic [4:0]                irq_priority,
  output logic                      sys_reset,
  output irq_lp_pkg::clk_gate_t     clk_gate,
  // event sources
  input  wire irq_lp_pkg::reset_src_t reset_src,
  input  wire irq_lp_pkg::mask_req_t  mask_req,
  input  wire logic                 nmi_pin_event,
  input  wire logic                 osc_fault_event,
  input  wire logic                 flash_access_event,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  power_mode_t mode_q;
  power_mode_t saved_mode_q;
  logic        in_service_q;
  logic [4:0]  svc_pri_q;
  logic        tuned_osc_q;
  logic [3:0]  nmi_en_q;        // wdt unused bit0, osc, pin nmi, flash
  logic [4:0]  flags_q;         // pin nmi, ext rst, por, osc, flash acc
  logic        fetch_fault_q;
  logic        por_seen_q;
  logic        reset_hold_q;
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // priority encoder result
  logic        pend;
  logic [15:0] pend_vec;
  logic [4:0]  pend_pri;
  logic        nmi_pend;
  logic        fetch_bad;
  logic        reset_cause;

  // forbidden fetch decode, reused for range checks
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // fetch from peripherals or unmapped space
  always_comb
  begin
    fetch_bad = fetch_valid &&
                !in_range(fetch_addr, RAM_BASE, RAM_TOP) &&
                !in_range(fetch_addr, INFO_BASE, INFO_TOP) &&
                !in_range(fetch_addr, CODE_BASE, VEC_TOP);
  end

  assign reset_cause = reset_src.power_up | reset_src.ext_reset |
                       reset_src.watchdog | reset_src.key_violation |
                       fetch_fault_q;

  // registered fetch fault, reset stands while a bad fetch does
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fetch_fault_q <= 1'b0;
    else
      fetch_fault_q <= fetch_bad;
  end

  // system reset output, held one cycle after the cause
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reset_hold_q <= 1'b0;
    else
      reset_hold_q <= reset_cause;
  end
  assign sys_reset = reset_hold_q;

  // non-maskable flags: hardware set wins over software clear
  logic        flag_wr;
  logic [4:0]  flag_clr;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_q <= FLAGS_RST;
    else
    begin
      flags_q[4] <= nmi_pin_event | (flags_q[4] & ~flag_clr[4]);
      flags_q[3] <= reset_src.ext_reset | (flags_q[3] & ~flag_clr[3]);
      flags_q[2] <= reset_src.power_up | (flags_q[2] & ~flag_clr[2]);
      flags_q[1] <= osc_fault_event | (flags_q[1] & ~flag_clr[1]);
      flags_q[0] <= flash_access_event | (flags_q[0] & ~flag_clr[0]);
    end
  end

  // own enables only, global enable ignored here
  assign nmi_pend = (flags_q[4] & nmi_en_q[2]) |
                    (flags_q[1] & nmi_en_q[1]) |
                    (flags_q[0] & nmi_en_q[3]);

  // fixed-priority selection, highest number first
  always_comb
  begin
    pend     = 1'b1;
    pend_vec = VEC_NMI;
    pend_pri = PRI_NMI;
    if (nmi_pend)
    begin
      pend_vec = VEC_NMI;
      pend_pri = PRI_NMI;
    end
    else if (!gie)
      pend = 1'b0;
    else if (HAS_COMPARATOR && mask_req.comparator_flag)
    begin
      pend_vec = VEC_COMP;
      pend_pri = PRI_COMP;
    end
    else if (mask_req.watchdog_flag)
    begin
      pend_vec = VEC_WDT;
      pend_pri = PRI_WDT;
    end
    else if (mask_req.timer_ch0_flag)
    begin
      pend_vec = VEC_TMR0;
      pend_pri = PRI_TMR0;
    end
    else if (mask_req.timer_ch1_flag || mask_req.timer_overflow_flag)
    begin
      pend_vec = VEC_TMR1;
      pend_pri = PRI_TMR1;
    end
    else if (|mask_req.port2_change_flags)
    begin
      pend_vec = VEC_PORT2;
      pend_pri = PRI_PORT2;
    end
    else if (|mask_req.port1_change_flags)
    begin
      pend_vec = VEC_PORT1;
      pend_pri = PRI_PORT1;
    end
    else
      pend = 1'b0;  // ffde..ffc0 never selected
  end

  // request to the core; one service at a time
  assign irq_req         = pend && !in_service_q;
  assign irq_vector_addr = pend_vec;
  assign irq_priority    = pend_pri;

  // service tracking and power-mode state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q       <= active_run_state;
      saved_mode_q <= active_run_state;
      in_service_q <= 1'b0;
      svc_pri_q    <= 5'h00;
      por_seen_q   <= 1'b0;
    end
    else if (reset_cause)
    begin
      mode_q       <= active_run_state;
      saved_mode_q <= active_run_state;
      in_service_q <= 1'b0;
      por_seen_q   <= 1'b0;
    end
    else if (reset_vec_valid && !por_seen_q)
    begin
      por_seen_q <= 1'b1;
      if (reset_vec_word == ERASED_WORD)
        mode_q <= sleep_level_four;
    end
    else if (irq_req && irq_ack)
    begin
      in_service_q <= 1'b1;
      svc_pri_q    <= pend_pri;
      saved_mode_q <= mode_q;
      mode_q       <= active_run_state;
    end
    else if (in_service_q && irq_return)
    begin
      in_service_q <= 1'b0;
      mode_q       <= saved_mode_q;
    end
    else if (mode_req_valid && !in_service_q)
    begin
      unique case (mode_req)
        3'd1:    mode_q <= sleep_level_zero;
        3'd2:    mode_q <= sleep_level_one;
        3'd3:    mode_q <= sleep_level_two;
        3'd4:    mode_q <= sleep_level_three;
        3'd5:    mode_q <= sleep_level_four;
        default: mode_q <= active_run_state;
      endcase
    end
  end

  // clock and oscillator gating per mode
  always_comb
  begin
    clk_gate = '0;
    unique case (mode_q)
      active_run_state:
        clk_gate = 6'b111111;
      sleep_level_zero:
        clk_gate = 6'b001111;
      sleep_level_one:
        clk_gate = {4'b0011, tuned_osc_q, 1'b1};
      sleep_level_two:
        clk_gate = 6'b000111;
      sleep_level_three:
        clk_gate = 6'b000101;
      sleep_level_four:
        clk_gate = 6'b000000;
    endcase
  end

  // axi4-lite write channels taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (flag_wr)
      begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign flag_wr       = aw_q && w_q;
  assign flag_clr      = (flag_wr && awaddr_q == OFS_FLAGS && wstrb_q[0])
                         ? wdata_q[4:0] : 5'h00;  // write one to clear

  // software-written enables and oscillator config
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nmi_en_q     <= ENABLE_RST;
      tuned_osc_q  <= 1'b1;
    end
    else if (flag_wr && wstrb_q[0])
    begin
      if (awaddr_q == OFS_ENABLE)
        nmi_en_q <= wdata_q[3:0];
      if (awaddr_q == OFS_CFG)
        tuned_osc_q <= wdata_q[0];
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (flag_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q == OFS_ENABLE || awaddr_q == OFS_FLAGS ||
                       awaddr_q == OFS_CFG) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_MODE:   s_axi_rdata <= {26'h0, mode_q};
        OFS_ENABLE: s_axi_rdata <= {28'h0, nmi_en_q};
        OFS_FLAGS:  s_axi_rdata <= {27'h0, flags_q};
        OFS_STATUS: s_axi_rdata <= {16'h0, in_service_q, 2'b00,
                                    svc_pri_q, 8'h00};
        OFS_CFG:    s_axi_rdata <= {31'h0, tuned_osc_q};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// *** verification/irq_lp_chk_sva.sv ***
// checker: port-level properties of the interrupt and power-mode block
`timescale 1ns/1ps
module irq_lp_chk
  import irq_lp_pkg::*;
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    fetch_valid,
  input wire logic [15:0]             fetch_addr,
  input wire logic                    gie,
  input wire logic                    irq_ack,
  input wire logic                    irq_req,
  input wire logic [15:0]             irq_vector_addr,
  input wire logic [4:0]              irq_priority,
  input wire logic                    sys_reset,
  input wire irq_lp_pkg::clk_gate_t   clk_gate,
  input wire irq_lp_pkg::reset_src_t  reset_src
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // reset causes and fetch guard
  AST_RESET_CAUSE: assert property (|reset_src |=> sys_reset)
    else $error("reset cause gave no system reset");
  AST_FETCH_GUARD: assert property (fetch_valid &&
    fetch_addr <= PERIPH_TOP |-> ##2 sys_reset)
    else $error("fetch from register space gave no reset");

  // vector placement and masking
  AST_VEC_MAP: assert property (irq_req
    |-> irq_vector_addr == {10'h3ff, irq_priority, 1'b0})
    else $error("vector address does not match priority slot");
  AST_GIE_MASK: assert property (irq_req && !gie
    |-> irq_priority >= PRI_NMI)
    else $error("maskable request while global enable off");

  // acceptance wakes the core and blocks further requests
  AST_ACK_WAKE: assert property (irq_req && irq_ack
    |=> clk_gate.cpu_run && !irq_req)
    else $error("accepted request did not wake core");
  AST_IN_SERVICE: assert property (irq_req && irq_ack
    |=> !irq_req [*3])
    else $error("new request during service");

  // clock gating per mode
  AST_ACTIVE_CLKS: assert property (clk_gate.cpu_run
    |-> clk_gate == 6'h3f)
    else $error("clock off while core runs");
  AST_SLEEP_LOW: assert property (!clk_gate.cpu_run &&
    clk_gate.peripheral_submain_clock_en
    |-> !clk_gate.main_clk_en && clk_gate.aux_clk_en)
    else $error("light sleep gating wrong");
  AST_SLEEP_MID: assert property (clk_gate.aux_clk_en &&
    !clk_gate.peripheral_submain_clock_en
    |-> !clk_gate.cpu_run && !clk_gate.main_clk_en && clk_gate.crystal_en)
    else $error("mid sleep gating wrong");
  AST_SLEEP_DEEP: assert property (!clk_gate.aux_clk_en
    |-> clk_gate == 6'h00)
    else $error("deepest sleep left something running");
endmodule

bind vectored_interrupt_lowpower_ctl irq_lp_chk chk (.*);

// *** verification/core_model.sv ***
// processor core stand-in: accepts requests and returns from handlers
`timescale 1ns/1ps
module core_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic irq_req,
  input  wire logic slow,
  output logic      irq_ack,
  output logic      irq_return
);
  logic [1:0] st_q;
  logic [4:0] cnt_q;

  // accept after 0 or 3 cycles, handler runs 20 cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= 2'h0;
      cnt_q <= 5'h00;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
    end
    else
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      cnt_q <= cnt_q + 5'h01;
      case (st_q)
        2'h0: if (irq_req)
        begin
          cnt_q <= 5'h00;
          st_q <= 2'h1;
        end
        2'h1: if (cnt_q >= (slow ? 5'h03 : 5'h00))
        begin
          irq_ack <= irq_req;
          st_q <= irq_req ? 2'h2 : 2'h0;
          cnt_q <= 5'h00;
        end
        2'h2: if (cnt_q == 5'h14)
        begin
          irq_return <= 1'b1;
          st_q <= 2'h3;
        end
        default: st_q <= 2'h0;
      endcase
    end
  end
endmodule

// *** verification/vectored_interrupt_lowpower_ctl_tb.sv ***
// testbench: bus, interrupt, fetch and power-mode sequences
`timescale 1ns/1ps
module vectored_interrupt_lowpower_ctl_tb;
  import irq_lp_pkg::*;
  logic aclk, aresetn, fetch_valid, reset_vec_valid, gie, mode_req_valid;
  logic irq_ack, irq_return, irq_req, sys_reset, slow;
  logic nmi_pin_event, osc_fault_event, flash_access_event;
  logic [15:0] fetch_addr, reset_vec_word, irq_vector_addr;
  logic [2:0] mode_req;
  logic [4:0] irq_priority;
  clk_gate_t clk_gate;
  reset_src_t reset_src;
  mask_req_t mask_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [5:0] gtab [6] = '{6'h3f, 6'h0f, 6'h0d, 6'h07, 6'h05, 6'h00};
  logic [15:0] ftab [10] = '{16'h0000, 16'h01ff, 16'h0200, 16'h027f,
    16'h0280, 16'h1000, 16'h10ff, 16'h1100, 16'hf800, 16'hffff};
  logic [0:9] fexp = 10'h324;
  logic [14:0] mtab [5] = '{15'h4000, 15'h2000, 15'h0400, 15'h0200,
    15'h0080};
  logic [4:0] ptab [5] = '{5'h1b, 5'h1a, 5'h18, 5'h13, 5'h12};
  int errors = 0;
  int tests_run = 0;

  vectored_interrupt_lowpower_ctl dut (.*);
  core_model core (.*);

  always #50 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one axi-lite write or read, waits for the answer
  task automatic bus(input bit w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] qo, output logic [1:0] ro);
    int n;
    logic ta, td, te;
    n = 0;
    te = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    while (!te && n < 100)
    begin
      @(negedge aclk);
      ta = w ? s_axi_awvalid && s_axi_awready
             : s_axi_arvalid && s_axi_arready;
      td = s_axi_wvalid && s_axi_wready;
      te = w ? s_axi_bvalid : s_axi_rvalid;
      qo = s_axi_rdata;
      ro = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta)
        {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (td)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk(n < 100, 1);
  endtask

  task automatic setm(input int m);
    @(posedge aclk);
    mode_req <= 3'(m);
    mode_req_valid <= 1'b1;
    @(posedge aclk);
    mode_req_valid <= 1'b0;
    repeat (2) @(negedge aclk);
  endtask

  // one interrupt service: vector, wake, clear source, resume
  task automatic serve(input logic [4:0] p, input logic [14:0] c,
    input logic [5:0] g);
    int n;
    n = 0;
    while (irq_req !== 1'b1 && n < 50)
    begin
      @(negedge aclk);
      n++;
    end
    chk(irq_vector_addr, {10'h3ff, p, 1'b0});
    chk(irq_priority, p);
    while (irq_ack !== 1'b1 && n < 100)
    begin
      @(negedge aclk);
      n++;
    end
    @(negedge aclk);
    chk(clk_gate.cpu_run, 1);
    if (c == 15'h0000)
    begin
      bus(0, OFS_FLAGS, 0, q, r);
      chk(q[4], 1);
      bus(1, OFS_FLAGS, 32'h10, q, r);
    end
    else
    begin
      @(posedge aclk);
      mask_req <= mask_req & ~c;
    end
    while (irq_return !== 1'b1 && n < 200)
    begin
      @(negedge aclk);
      n++;
    end
    repeat (3) @(negedge aclk);
    chk(clk_gate, g);
    chk(n < 200, 1);
  endtask

  initial
  begin
    #2000000;
    errors++;
    complete_run;
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {fetch_valid, reset_vec_valid, gie, mode_req_valid, slow} = '0;
    {fetch_addr, reset_vec_word, mode_req, reset_src, mask_req} = '0;
    {nmi_pin_event, osc_fault_event, flash_access_event} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(clk_gate, 6'h3f);
    chk(irq_req, 0);
    bus(0, OFS_ENABLE, 0, q, r);
    chk(q, ENABLE_RST);
    bus(0, 8'h20, 0, q, r);
    chk(r, RESP_SLVERR);
    // every mode, tuned oscillator off then on
    for (int t = 0; t < 2; t++)
    begin
      bus(1, OFS_CFG, t, q, r);
      for (int m = 0; m < 7; m++)
      begin
        setm(m % 6);
        chk(clk_gate, (m == 2 && t == 1) ? 6'h0f : gtab[m % 6]);
        bus(0, OFS_MODE, 0, q, r);
        chk(q, 32'h1 << (m % 6));
      end
    end
    // three pending at once from sleep three
    setm(4);
    @(posedge aclk);
    gie <= 1'b1;
    slow <= 1'b1;
    mask_req <= 15'h1808;
    serve(5'h19, 15'h1000, 6'h05);
    serve(5'h18, 15'h0800, 6'h05);
    serve(5'h12, 15'h0008, 6'h05);
    setm(0);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge aclk);
      mask_req <= mtab[i];
      slow <= i[0];
      serve(ptab[i], mtab[i], 6'h3f);
    end
    // global enable blocks maskable, own enable blocks nmi sources
    @(posedge aclk);
    gie <= 1'b0;
    mask_req <= 15'h4000;
    osc_fault_event <= 1'b1;
    @(posedge aclk);
    osc_fault_event <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(irq_req, 0);
    @(posedge aclk);
    mask_req <= '0;
    bus(1, OFS_FLAGS, 32'h1f, q, r);
    bus(1, OFS_ENABLE, 32'h4, q, r);
    chk(r, RESP_OKAY);
    @(posedge aclk);
    nmi_pin_event <= 1'b1;
    @(posedge aclk);
    nmi_pin_event <= 1'b0;
    serve(5'h1e, 15'h0000, 6'h3f);
    // flash access source through the shared slot
    bus(1, OFS_ENABLE, 32'h8, q, r);
    @(posedge aclk);
    flash_access_event <= 1'b1;
    @(posedge aclk);
    flash_access_event <= 1'b0;
    @(negedge aclk);
    chk(irq_req, 1);
    chk(irq_priority, PRI_NMI);
    bus(1, OFS_FLAGS, 32'h01, q, r);
    repeat (40) @(negedge aclk);
    chk(irq_req, 0);
    chk(clk_gate, 6'h3f);
    // fetch guard over range edges
    for (int i = 0; i < 10; i++)
    begin
      @(posedge aclk);
      fetch_valid <= 1'b1;
      fetch_addr <= ftab[i];
      @(posedge aclk);
      fetch_valid <= 1'b0;
      repeat (2) @(negedge aclk);
      chk(sys_reset, fexp[i]);
      repeat (2) @(negedge aclk);
    end
    // each reset cause, power-up last
    for (int i = 0; i < 4; i++)
    begin
      @(posedge aclk);
      reset_src <= 4'(1 << i);
      @(posedge aclk);
      reset_src <= '0;
      @(negedge aclk);
      chk(sys_reset, 1);
      repeat (2) @(negedge aclk);
    end
    bus(0, OFS_FLAGS, 0, q, r);
    chk(q[2], 1);
    // erased reset vector after power-up
    @(posedge aclk);
    reset_vec_valid <= 1'b1;
    reset_vec_word <= ERASED_WORD;
    @(posedge aclk);
    reset_vec_valid <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(clk_gate, 6'h00);
    complete_run;
  end
endmodule
